// [rtl/pseq_regs.vh]
// timing constants and encodings for the power sequencer
`ifndef PSEQ_REGS_VH
`define PSEQ_REGS_VH
`define PSEQ_CLK_MHZ 200
`define PSEQ_DEBOUNCE_MS 30
`define PSEQ_DEBOUNCE_CYC (`PSEQ_DEBOUNCE_MS * 1000 * `PSEQ_CLK_MHZ)
`define PSEQ_WDOG_US 150
`define PSEQ_WDOG_CYC (`PSEQ_WDOG_US * `PSEQ_CLK_MHZ)
`define PSEQ_LONGPRESS_MS 1000
`define PSEQ_LONGPRESS_CYC (`PSEQ_LONGPRESS_MS * 1000 * `PSEQ_CLK_MHZ)
`define PSEQ_STEP_CYC 16
`define PSEQ_CORE_1V8 2'h1
`endif

// [rtl/pseq_power_sequencer.v]
// power on/off sequencer of the power-management companion device
`timescale 1ns/10ps
`default_nettype none
`include "pseq_regs.vh"
// Contract
// - a power button press debounced for more than 30 ms starts power-up.
// - a rising edge on the clock alarm input starts power-up.
// - a charger above battery by more than 0.4 V starts power-up.
// - power-up first enables the local oscillator, then the band-gap references.
// - with references on, battery must be above 3.2 V before power-up continues.
// - after the battery check the charge pump is enabled, then all five regulators.
// - after the regulators the supply-on indicator goes high, then system reset is released.
// - a long press of the power button while running starts normal power-off.
// - power-off first starts a 150 us watchdog and disables DC/DC before indicator low.
// - after indicator low, regulators, then references, then oscillator are disabled.
// - battery below 2.7 V starts emergency power-off with no user action.
// - emergency power-off first drives the fast interrupt low, then the normal steps.
// - core regulator voltage is selectable among 2.5, 1.8, 1.4, 1.2 V, set to 1.8 V.
// - only core, memory and peripheral regulators may run from backup supply.
// - below 3.2 V the battery is trickle charged at 20 mA, above that the processor steers it.
module pseq_power_sequencer #(
  parameter DEBOUNCE_CYC = `PSEQ_DEBOUNCE_CYC,
  parameter WDOG_CYC = `PSEQ_WDOG_CYC,
  parameter LONGPRESS_CYC = `PSEQ_LONGPRESS_CYC
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire power_button_n_i,
  input wire clock_alarm_irq_i,
  input wire charger_voltage_sense_i,
  input wire bat_above_3v2_i,
  input wire bat_below_2v7_i,
  input wire backup_mode_i,
  input wire proc_charge_ctrl_i,
  output reg low_freq_osc_en_o,
  output reg bandgap_en_o,
  output reg pump_output_en_o,
  output reg [4:0] ldo_en_o,
  output reg [1:0] core_vsel_o,
  output reg [4:0] ldo_backup_o,
  output reg dcdc_en_o,
  output reg supply_on_o,
  output reg system_reset_n_o,
  output reg fast_irq_line_n_o,
  output reg wdog_run_o,
  output reg trickle_en_o,
  output reg charge_switch_ctrl_o
);

// ---------------------------------------------------------------
// state codes
// ---------------------------------------------------------------
localparam S_OFF = 4'h0;
localparam S_OSC = 4'h1;
localparam S_BG = 4'h2;
localparam S_BCHK = 4'h3;
localparam S_PUMP = 4'h4;
localparam S_LDO = 4'h5;
localparam S_IND = 4'h6;
localparam S_RUN = 4'h7;
localparam S_FIQ = 4'h8;
localparam S_WDOG = 4'h9;
localparam S_INDL = 4'ha;
localparam S_LDOFF = 4'hb;
localparam S_BGOFF = 4'hc;
localparam S_OSCOFF = 4'hd;
// regulators with backup capability: core, memory i/o, peripheral i/o
localparam [4:0] BACKUP_MASK = 5'h0d;

// ---------------------------------------------------------------
// input synchronisers
// ---------------------------------------------------------------
reg [6:0] meta_q;
reg [6:0] sync_q;
// every input but sys_rst_i is asynchronous to clock_i, two flops before use
always @(posedge clock_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    meta_q <= 7'h01;
    sync_q <= 7'h01;
  end
  else
  begin
    meta_q <= {proc_charge_ctrl_i, backup_mode_i, bat_below_2v7_i, bat_above_3v2_i,
      charger_voltage_sense_i, clock_alarm_irq_i, power_button_n_i};
    sync_q <= meta_q;
  end
end
wire btn_n = sync_q[0];
wire alarm = sync_q[1];
wire chg_ok = sync_q[2];
wire bat_ok = sync_q[3];
wire bat_low = sync_q[4];
wire backup = sync_q[5];
wire proc_chg = sync_q[6];

// ---------------------------------------------------------------
// button press timer and alarm edge
// ---------------------------------------------------------------
reg [31:0] press_q;
reg alarm_q;
reg btn_prev_q;
reg pressed_q;
// counts low time after a falling edge; a bounce back high restarts it
always @(posedge clock_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    press_q <= 32'h0;
    alarm_q <= 1'b0;
    btn_prev_q <= 1'b1;
    pressed_q <= 1'b0;
  end
  else
  begin
    alarm_q <= alarm;
    btn_prev_q <= btn_n;
    if (btn_n)
      pressed_q <= 1'b0;
    else if (btn_prev_q)
      pressed_q <= 1'b1; // falling edge seen
    if (btn_n || btn_prev_q)
      press_q <= 32'h0;
    else if (press_q != 32'hffffffff)
      press_q <= press_q + 32'h1;
  end
end
wire wake_button = pressed_q && (press_q > DEBOUNCE_CYC);
wire wake_alarm = alarm && !alarm_q;
wire wake_charger = chg_ok;
wire long_press = pressed_q && (press_q >= LONGPRESS_CYC);

// ---------------------------------------------------------------
// sequencer
// ---------------------------------------------------------------
reg [3:0] state_q;
reg [3:0] state_d;
reg [31:0] tmr_q;
reg emerg_q;
wire step_done = (tmr_q >= `PSEQ_STEP_CYC);
wire wd_done = (tmr_q >= WDOG_CYC);
// next state; each step dwells a short settling time, S_WDOG the watchdog time
always @*
begin
  state_d = state_q;
  case (state_q)
    S_OFF:
      if (wake_button || wake_alarm || wake_charger)
        state_d = S_OSC;
    S_OSC: if (step_done) state_d = S_BG;
    S_BG: if (step_done) state_d = S_BCHK;
    S_BCHK:
      if (step_done)
        state_d = bat_ok ? S_PUMP : S_BGOFF;
    S_PUMP: if (step_done) state_d = S_LDO;
    S_LDO: if (step_done) state_d = S_IND;
    S_IND: if (step_done) state_d = S_RUN;
    S_RUN:
      if (bat_low)
        state_d = S_FIQ;
      else if (long_press)
        state_d = S_WDOG;
    S_FIQ: if (step_done) state_d = S_WDOG;
    S_WDOG: if (wd_done) state_d = S_INDL;
    S_INDL: if (step_done) state_d = S_LDOFF;
    S_LDOFF: if (step_done) state_d = S_BGOFF;
    S_BGOFF: if (step_done) state_d = S_OSCOFF;
    S_OSCOFF:
      // wait for the button to be let go so the same press cannot re-wake
      if (step_done && btn_n && !chg_ok)
        state_d = S_OFF;
    default: state_d = S_OFF;
  endcase
end

// state register, dwell timer and emergency mark
always @(posedge clock_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    state_q <= S_OFF;
    tmr_q <= 32'h0;
    emerg_q <= 1'b0;
  end
  else
  begin
    state_q <= state_d;
    if (state_d != state_q)
      tmr_q <= 32'h0;
    else if (tmr_q != 32'hffffffff)
      tmr_q <= tmr_q + 32'h1;
    if (state_q == S_FIQ)
      emerg_q <= 1'b1;
    else if (state_q == S_OFF)
      emerg_q <= 1'b0;
  end
end

// ---------------------------------------------------------------
// outputs, all registered; sequence enables decoded from the next state
// ---------------------------------------------------------------
wire on_osc = (state_d != S_OFF) && (state_d != S_OSCOFF);
wire on_bg = on_osc && (state_d != S_OSC) && (state_d != S_BGOFF);
wire on_pump = (state_d >= S_PUMP) && (state_d <= S_LDOFF) && (state_d != S_LDOFF);
wire on_ldo = (state_d >= S_LDO) && (state_d <= S_INDL);
// indicator holds through the watchdog wait so dc/dc is off before it drops
wire on_ind = (state_d >= S_IND) && (state_d <= S_WDOG);
always @(posedge clock_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    low_freq_osc_en_o <= 1'b0;
    bandgap_en_o <= 1'b0;
    pump_output_en_o <= 1'b0;
    ldo_en_o <= 5'h00;
    core_vsel_o <= `PSEQ_CORE_1V8;
    ldo_backup_o <= 5'h00;
    dcdc_en_o <= 1'b0;
    supply_on_o <= 1'b0;
    system_reset_n_o <= 1'b0;
    fast_irq_line_n_o <= 1'b1;
    wdog_run_o <= 1'b0;
    trickle_en_o <= 1'b0;
    charge_switch_ctrl_o <= 1'b0;
  end
  else
  begin
    low_freq_osc_en_o <= on_osc;
    bandgap_en_o <= on_bg;
    pump_output_en_o <= on_pump;
    ldo_en_o <= on_ldo ? 5'h1f : 5'h00;
    core_vsel_o <= `PSEQ_CORE_1V8;
    ldo_backup_o <= backup ? BACKUP_MASK : 5'h00;
    dcdc_en_o <= on_ldo && (state_d != S_WDOG) && (state_d != S_INDL);
    supply_on_o <= on_ind;
    // reset is released one step after the indicator; on power-off it drops on leaving S_RUN, before the indicator
    system_reset_n_o <= (state_d == S_RUN);
    fast_irq_line_n_o <= !((state_d >= S_FIQ) && (emerg_q || state_d == S_FIQ)
      && (state_d != S_OFF));
    wdog_run_o <= (state_d == S_WDOG);
    // trickle only while a charger is present and the battery is deep
    trickle_en_o <= chg_ok && !bat_ok;
    charge_switch_ctrl_o <= chg_ok && (bat_ok ? proc_chg : 1'b1);
  end
end

endmodule
`default_nettype wire

// [testbench/pseq_props.sv]
// port assertions for the power sequencer
`timescale 1ns/10ps
`default_nettype none
module pseq_props (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic bat_above_3v2_i,
  input wire logic bat_below_2v7_i,
  input wire logic low_freq_osc_en_o,
  input wire logic bandgap_en_o,
  input wire logic pump_output_en_o,
  input wire logic [4:0] ldo_en_o,
  input wire logic [1:0] core_vsel_o,
  input wire logic [4:0] ldo_backup_o,
  input wire logic dcdc_en_o,
  input wire logic supply_on_o,
  input wire logic system_reset_n_o,
  input wire logic fast_irq_line_n_o,
  input wire logic trickle_en_o,
  input wire logic charge_switch_ctrl_o
);
  // ----
  // sequence order and fixed settings
  // ----
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // low battery while running, synchroniser adds a few cycles
  sequence s_emerg;
    supply_on_o && bat_below_2v7_i;
  endsequence
  osc_first_a: assert property ($rose(bandgap_en_o) |-> $past(low_freq_osc_en_o, 8))
    else $error("band-gap rose without oscillator");
  bat_gate_a: assert property ($rose(pump_output_en_o) |-> $past(bat_above_3v2_i, 4))
    else $error("pump enabled with low battery");
  ldo_pump_a: assert property (ldo_en_o != 5'h00 |-> ldo_en_o == 5'h1f && pump_output_en_o)
    else $error("regulators on without pump");
  son_ldo_a: assert property (supply_on_o |-> ldo_en_o == 5'h1f)
    else $error("indicator high without regulators");
  rst_after_son_a: assert property ($rose(system_reset_n_o) |-> $past(supply_on_o, 8))
    else $error("reset released too early");
  wdog_dcdc_a: assert property ($fell(supply_on_o) |-> $past(dcdc_en_o, 32) == 1'b0)
    else $error("indicator low before watchdog wait");
  off_order_a: assert property ($fell(bandgap_en_o) |-> ldo_en_o == 5'h00 && low_freq_osc_en_o)
    else $error("band-gap off out of order");
  emerg_irq_a: assert property (s_emerg |-> ##[1:6] !fast_irq_line_n_o)
    else $error("no fast interrupt on low battery");
  irq_first_a: assert property ($fell(fast_irq_line_n_o) |-> supply_on_o)
    else $error("fast interrupt after indicator low");
  core_sel_a: assert property (core_vsel_o == 2'h1)
    else $error("core voltage code wrong");
  backup_set_a: assert property (ldo_backup_o[1] == 1'b0 && ldo_backup_o[4] == 1'b0)
    else $error("backup on a regulator without backup");
  trickle_sw_a: assert property (trickle_en_o |-> charge_switch_ctrl_o)
    else $error("trickle without charge switch");
endmodule
bind pseq_power_sequencer pseq_props i_props (.*);
`default_nettype wire

// [testbench/pseq_bb_model.sv]
// baseband processor stand-in: clock enable and charge request
`timescale 1ns/10ps
`default_nettype none
module pseq_bb_model #(parameter logic [3:0] CLK_DLY = 4'h4) (
  input wire logic clock_i,
  input wire logic system_reset_n_i,
  input wire logic fast_irq_line_n_i,
  output wire logic clk13_en_o,
  output wire logic chg_req_o
);
  logic [3:0] cnt_q;
  // system clock starts a few cycles after reset lets go
  always @(posedge clock_i)
  begin
    if (!system_reset_n_i)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  end
  assign clk13_en_o = (cnt_q >= CLK_DLY);
  // charging is dropped at once on a low battery warning
  assign chg_req_o = system_reset_n_i & fast_irq_line_n_i;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the power sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, btn_n = 1'b1, alarm = 1'b0, chg = 1'b0;
  logic bat_ok = 1'b1, bat_low = 1'b0, bkup = 1'b1, chg_req, clk13;
  logic osc, bg, pump, dcdc, son, rst_n, fiq_n, wd, trk, csw;
  logic [4:0] ldo, ldo_bk;
  logic [1:0] vsel;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // ----
  // design and partner
  // ----
  pseq_power_sequencer #(.DEBOUNCE_CYC(20), .WDOG_CYC(40), .LONGPRESS_CYC(200)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .power_button_n_i(btn_n),
    .clock_alarm_irq_i(alarm), .charger_voltage_sense_i(chg), .bat_above_3v2_i(bat_ok),
    .bat_below_2v7_i(bat_low), .backup_mode_i(bkup), .proc_charge_ctrl_i(chg_req),
    .low_freq_osc_en_o(osc), .bandgap_en_o(bg), .pump_output_en_o(pump), .ldo_en_o(ldo),
    .core_vsel_o(vsel), .ldo_backup_o(ldo_bk), .dcdc_en_o(dcdc), .supply_on_o(son),
    .system_reset_n_o(rst_n), .fast_irq_line_n_o(fiq_n), .wdog_run_o(wd),
    .trickle_en_o(trk), .charge_switch_ctrl_o(csw));
  pseq_bb_model i_bb (.clock_i(clock_i), .system_reset_n_i(rst_n),
    .fast_irq_line_n_i(fiq_n), .clk13_en_o(clk13), .chg_req_o(chg_req));
  initial
    forever #2.5 clock_i = ~clock_i;
  // hang guard, tests need about 1100 cycles
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for fully up (1) or fully down (0), bounded
  task automatic wait_lvl(input logic want);
    int n;
    n = 0;
    while (!(rst_n === want && osc === want) && n < 600)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_button;
    btn_n = 1'b0;
    repeat (10) @(negedge clock_i);
    btn_n = 1'b1;
    repeat (40) @(negedge clock_i);
    chk(5'(osc), 5'h0);
    btn_n = 1'b0;
    repeat (20) @(negedge clock_i);
    chk(5'(osc), 5'h0);
    wait_lvl(1'b1);
    btn_n = 1'b1;
    chk(5'({son, pump}), 5'h3);
    chk(ldo, 5'h1f);
    chk(5'(dcdc), 5'h1);
    chk(ldo_bk, 5'h0d);
    chk(5'(vsel), 5'h1);
    repeat (8) @(negedge clock_i);
    chk(5'(clk13), 5'h1);
  endtask
  task t_long;
    btn_n = 1'b0;
    repeat (100) @(negedge clock_i);
    btn_n = 1'b1;
    repeat (10) @(negedge clock_i);
    chk(5'(son), 5'h1);
    btn_n = 1'b0;
    wait_lvl(1'b0);
    btn_n = 1'b1;
    chk({son, dcdc, pump, bg, fiq_n}, 5'h01);
  endtask
  task t_alarm_emerg;
    // let the sequencer settle back into off, wakes are ignored before that
    repeat (30) @(negedge clock_i);
    alarm = 1'b1;
    wait_lvl(1'b1);
    alarm = 1'b0;
    chk(5'(rst_n), 5'h1);
    bat_low = 1'b1;
    repeat (6) @(negedge clock_i);
    chk(5'({fiq_n, son}), 5'h1);
    repeat (20) @(negedge clock_i);
    chk(5'({wd, dcdc, son}), 5'h5);
    wait_lvl(1'b0);
    chk({son, dcdc, pump, bg, osc}, 5'h00);
    bat_low = 1'b0;
  endtask
  task t_chg_fail;
    repeat (30) @(negedge clock_i);
    bat_ok = 1'b0;
    chg = 1'b1;
    repeat (8) @(negedge clock_i);
    chk(5'({trk, csw}), 5'h3);
    repeat (20) @(negedge clock_i);
    chk(5'(bg), 5'h1);
    chg = 1'b0;
    wait_lvl(1'b0);
    chk(5'({son, pump, rst_n}), 5'h0);
    bat_ok = 1'b1;
  endtask
  // charger with a healthy battery: the processor steers the switch once out of reset
  task t_chg_norm;
    repeat (30) @(negedge clock_i);
    bkup = 1'b0;
    chg = 1'b1;
    repeat (8) @(negedge clock_i);
    chk(5'({trk, csw}), 5'h0);
    chk(ldo_bk, 5'h00);
    wait_lvl(1'b1);
    repeat (4) @(negedge clock_i);
    chk(5'({trk, csw}), 5'h1);
  endtask
  initial
  begin
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    t_button;
    t_long;
    t_alarm_emerg;
    t_chg_fail;
    t_chg_norm;
    summarize;
  end
endmodule
`default_nettype wire
